// File: pmsar_regs.vh
// Function
// - Basic status bit 15 always reads zero: no four-pair 100 Mbps support.
// - Basic status bits 14 to 11 are read-only and always read one.
// - Basic status bit 5 reads one once auto-negotiation has completed.
// - Basic status bit 4 reads one while a far end fault is detected.
// - Basic status bit 3 reads the auto-negotiation enable, default one.
// - Basic status bit 0 reads zero: no extended register capability.
// - Identifier low word is a read-only fixed constant.
// - Identifier high word is a read-only fixed constant.
// - Advertisement bit 10, pause, is writable, default one, shared storage.
// - Advertisement bits 8 and 7, 100 Mbps duplex, writable, default one.
// - Advertisement bits 6 and 5, 10 Mbps duplex, writable, default one.
// - Partner ability bit 10 reads the partner pause capability.
// - Partner ability bits 8 and 7 read partner 100 Mbps abilities.
// - Partner ability bits 6 and 5 read partner 10 Mbps abilities.
`ifndef PMSAR_REGS_VH
`define PMSAR_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PMSAR_IDX_BASIC_STATUS 12'h4d2
`define PMSAR_IDX_IDENT_LOW 12'h4d4
`define PMSAR_IDX_IDENT_HIGH 12'h4d6
`define PMSAR_IDX_ADVERTISE 12'h4d8
`define PMSAR_IDX_PARTNER 12'h4da
`define PMSAR_IDX_INT_STATUS 12'h4dc
`define PMSAR_IDX_INT_MASK 12'h4de

// ----------------------------------------
// Basic status fields
// ----------------------------------------
`define PMSAR_BS_T4 15
`define PMSAR_BS_CAP_HI 14
`define PMSAR_BS_CAP_LO 11
`define PMSAR_BS_CAPS 4'hf
`define PMSAR_BS_AN_DONE 5
`define PMSAR_BS_FAR_FAULT 4
`define PMSAR_BS_AN_CAPABLE 3
`define PMSAR_BS_LINK 2
`define PMSAR_BS_EXTENDED 0

// ----------------------------------------
// Identifier words (arbitrary values)
// ----------------------------------------
`define PMSAR_IDENT_LOW_VAL 16'h5a5a
`define PMSAR_IDENT_HIGH_VAL 16'h00c3

// ----------------------------------------
// Advertisement and partner ability fields
// ----------------------------------------
`define PMSAR_ABIL_HI 10
`define PMSAR_ABIL_MID 8
`define PMSAR_ABIL_LO 5
`define PMSAR_ADV_RESET 5'h1f
`define PMSAR_ADV_SELECTOR 5'h01
`define PMSAR_AN_ENABLE_RESET 1'b1

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define PMSAR_EV_AN_DONE 0
`define PMSAR_EV_FAR_FAULT 1
`define PMSAR_EV_LINK 2
`define PMSAR_EV_PARTNER 3
`define PMSAR_EV_WIDTH 4

`endif

// File: pmsar_mirror.v
`timescale 1ns/1ps
// ----------------------------------------
// Mirror of status bits with change pulses
// ----------------------------------------
module pmsar_mirror #(
	parameter W = 3
) (
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q,
	output reg [W-1:0] rise,
	output reg changed
);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= {W{1'b0}};
			rise <= {W{1'b0}};
			changed <= 1'b0;
		end
		else
		begin
			q <= d_in;
			rise <= d_in & ~q;
			changed <= |(d_in ^ q);
		end
	end
endmodule // pmsar_mirror

// File: pmsar_event_irq.v
`timescale 1ns/1ps
`include "pmsar_regs.vh"
// ----------------------------------------
// Sticky event status, mask and interrupt
// ----------------------------------------
module pmsar_event_irq (
	input wire pclk,
	input wire presetn,
	input wire [`PMSAR_EV_WIDTH-1:0] ev,
	input wire clr_we,
	input wire mask_we,
	input wire [`PMSAR_EV_WIDTH-1:0] wdata,
	output reg [`PMSAR_EV_WIDTH-1:0] status,
	output reg [`PMSAR_EV_WIDTH-1:0] mask,
	output reg irq
);
	reg [`PMSAR_EV_WIDTH-1:0] next_status;
	reg [`PMSAR_EV_WIDTH-1:0] next_mask;

	always @*
	begin
		next_status = status;
		next_mask = mask;
		if (clr_we)
			next_status = status & ~wdata;
		// New event beats a simultaneous clear
		next_status = next_status | ev;
		if (mask_we)
			next_mask = wdata;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status <= {`PMSAR_EV_WIDTH{1'b0}};
			mask <= {`PMSAR_EV_WIDTH{1'b0}};
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			mask <= next_mask;
			irq <= |(next_status & next_mask);
		end
	end
endmodule // pmsar_event_irq

// File: pmsar_phy_regs.v
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "pmsar_regs.vh"
module pmsar_phy_regs (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire an_complete_in,
	input wire far_fault_in,
	input wire link_up_in,
	input wire [4:0] lp_ability_in,
	input wire an_enable_we,
	input wire an_enable_wdata,
	input wire adv_ability_we,
	input wire [4:0] adv_ability_wdata,
	output reg [4:0] adv_ability,
	output reg an_enable,
	output wire irq
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function hit;
		input [15:0] addr;
		input [11:0] idx;
		begin
			hit = (addr == {2'b00, idx, 2'b00});
		end
	endfunction

	wire sel_basic;
	wire sel_id_lo;
	wire sel_id_hi;
	wire sel_adv;
	wire sel_lp;
	wire sel_int_st;
	wire sel_int_mask;
	wire sel_any;

	assign sel_basic = hit(paddr, `PMSAR_IDX_BASIC_STATUS);
	assign sel_id_lo = hit(paddr, `PMSAR_IDX_IDENT_LOW);
	assign sel_id_hi = hit(paddr, `PMSAR_IDX_IDENT_HIGH);
	assign sel_adv = hit(paddr, `PMSAR_IDX_ADVERTISE);
	assign sel_lp = hit(paddr, `PMSAR_IDX_PARTNER);
	assign sel_int_st = hit(paddr, `PMSAR_IDX_INT_STATUS);
	assign sel_int_mask = hit(paddr, `PMSAR_IDX_INT_MASK);
	assign sel_any = sel_basic | sel_id_lo | sel_id_hi | sel_adv | sel_lp |
		sel_int_st | sel_int_mask;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	wire access_first;
	wire access_done;
	wire wr_done;

	// Answer one cycle into the access phase
	assign access_first = psel & penable & ~pready;
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite & sel_any;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (access_first)
		begin
			pready <= 1'b1;
			pslverr <= ~sel_any;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Advertisement storage, shared with port control
	// ----------------------------------------
	wire adv_bus_we;
	reg [4:0] next_adv;

	assign adv_bus_we = wr_done & sel_adv;

	always @*
	begin
		next_adv = adv_ability;
		if (adv_ability_we)
			next_adv = adv_ability_wdata;
		// Bus write wins over a same-cycle port control write
		if (adv_bus_we && pstrb[1])
			next_adv[4] = pwdata[`PMSAR_ABIL_HI];
		if (adv_bus_we && pstrb[1])
			next_adv[3] = pwdata[`PMSAR_ABIL_MID];
		if (adv_bus_we && pstrb[0])
			next_adv[2:0] = pwdata[7:5];
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			adv_ability <= `PMSAR_ADV_RESET;
		else
			adv_ability <= next_adv;
	end

	// ----------------------------------------
	// Auto-negotiation enable copy
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			an_enable <= `PMSAR_AN_ENABLE_RESET;
		else if (an_enable_we)
			an_enable <= an_enable_wdata;
	end

	// ----------------------------------------
	// Port status mirrors
	// ----------------------------------------
	wire [2:0] st_q;
	wire [2:0] st_rise;
	wire [4:0] lp_q;
	wire lp_changed;

	pmsar_mirror #(
		.W(3)
	) u_status_mirror (
		.pclk(pclk),
		.presetn(presetn),
		.d_in({link_up_in, far_fault_in, an_complete_in}),
		.q(st_q),
		.rise(st_rise),
		.changed()
	);

	pmsar_mirror #(
		.W(5)
	) u_partner_mirror (
		.pclk(pclk),
		.presetn(presetn),
		.d_in(lp_ability_in),
		.q(lp_q),
		.rise(),
		.changed(lp_changed)
	);

	// Link change is either edge; done and far fault use rising edge, partner any bit change
	reg link_prev;
	reg link_changed;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_prev <= 1'b0;
			link_changed <= 1'b0;
		end
		else
		begin
			link_prev <= st_q[2];
			link_changed <= st_q[2] ^ link_prev;
		end
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	wire [`PMSAR_EV_WIDTH-1:0] events;
	wire [`PMSAR_EV_WIDTH-1:0] int_status;
	wire [`PMSAR_EV_WIDTH-1:0] int_mask;
	wire int_clr_we;
	wire int_mask_we;

	assign events[`PMSAR_EV_AN_DONE] = st_rise[0];
	assign events[`PMSAR_EV_FAR_FAULT] = st_rise[1];
	assign events[`PMSAR_EV_LINK] = link_changed;
	assign events[`PMSAR_EV_PARTNER] = lp_changed;
	assign int_clr_we = wr_done & sel_int_st & pstrb[0];
	assign int_mask_we = wr_done & sel_int_mask & pstrb[0];

	pmsar_event_irq u_event_irq (
		.pclk(pclk),
		.presetn(presetn),
		.ev(events),
		.clr_we(int_clr_we),
		.mask_we(int_mask_we),
		.wdata(pwdata[`PMSAR_EV_WIDTH-1:0]),
		.status(int_status),
		.mask(int_mask),
		.irq(irq)
	);

	// ----------------------------------------
	// Register read values
	// ----------------------------------------
	reg [15:0] basic_word;
	reg [15:0] adv_word;
	reg [15:0] lp_word;
	reg [15:0] rd_word;

	always @*
	begin
		basic_word = 16'h0000;
		basic_word[`PMSAR_BS_T4] = 1'b0;
		basic_word[`PMSAR_BS_CAP_HI:`PMSAR_BS_CAP_LO] = `PMSAR_BS_CAPS;
		basic_word[`PMSAR_BS_AN_DONE] = st_q[0];
		basic_word[`PMSAR_BS_FAR_FAULT] = st_q[1];
		basic_word[`PMSAR_BS_AN_CAPABLE] = an_enable;
		basic_word[`PMSAR_BS_LINK] = st_q[2];
		basic_word[`PMSAR_BS_EXTENDED] = 1'b0;
	end

	always @*
	begin
		adv_word = 16'h0000;
		adv_word[`PMSAR_ABIL_HI] = adv_ability[4];
		adv_word[`PMSAR_ABIL_MID:`PMSAR_ABIL_LO] = adv_ability[3:0];
		adv_word[4:0] = `PMSAR_ADV_SELECTOR;
	end

	always @*
	begin
		lp_word = 16'h0000;
		lp_word[`PMSAR_ABIL_HI] = lp_q[4];
		lp_word[`PMSAR_ABIL_MID:7] = lp_q[3:2];
		lp_word[6:`PMSAR_ABIL_LO] = lp_q[1:0];
	end

	always @*
	begin
		rd_word = 16'h0000;
		if (sel_basic)
			rd_word = basic_word;
		else if (sel_id_lo)
			rd_word = `PMSAR_IDENT_LOW_VAL;
		else if (sel_id_hi)
			rd_word = `PMSAR_IDENT_HIGH_VAL;
		else if (sel_adv)
			rd_word = adv_word;
		else if (sel_lp)
			rd_word = lp_word;
		else if (sel_int_st)
			rd_word = {12'h000, int_status};
		else if (sel_int_mask)
			rd_word = {12'h000, int_mask};
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (access_first && !pwrite)
			prdata <= {16'h0000, rd_word};
		else
			prdata <= 32'h0000_0000;
	end

endmodule // pmsar_phy_regs

// File: pmsar_chk_asserts.sv
`timescale 1ns/1ps
`include "pmsar_regs.vh"
module pmsar_chk (
	input wire pclk,
	input wire presetn,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire an_complete_in,
	input wire far_fault_in,
	input wire [4:0] lp_ability_in,
	input wire [4:0] adv_ability,
	input wire an_enable
);
	// ----------------------------------------
	// Input stability counter
	// ----------------------------------------
	wire rd = pready & ~pwrite;
	wire [12:0] now = {an_complete_in, far_fault_in, an_enable, lp_ability_in, adv_ability};
	reg [12:0] prv;
	reg [2:0] st;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prv <= 13'h0000;
			st <= 3'h0;
		end
		else
		begin
			prv <= now;
			st <= (prv != now) ? 3'h0 : ((st == 3'h4) ? 3'h4 : st + 3'h1);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Register contents
	// ----------------------------------------
	AST_T4_EXT: assert property (rd && paddr == 16'h1348 |-> prdata[15] == 0 && prdata[0] == 0)
		else $error("basic status bit 15 or 0 set");
	AST_CAPS: assert property (rd && paddr == 16'h1348 |-> prdata[14:11] == 4'hf)
		else $error("capability bits not all one");
	AST_AN_DONE: assert property (rd && paddr == 16'h1348 && st == 4 |-> prdata[5] == an_complete_in)
		else $error("negotiation done bit wrong");
	AST_FAR: assert property (rd && paddr == 16'h1348 && st == 4 |-> prdata[4] == far_fault_in)
		else $error("far end fault bit wrong");
	AST_AN_CAP: assert property (rd && paddr == 16'h1348 && st == 4 |-> prdata[3] == an_enable)
		else $error("negotiation capable bit wrong");
	AST_ID_LOW: assert property (rd && paddr == 16'h1350 |-> prdata == {16'h0000, `PMSAR_IDENT_LOW_VAL})
		else $error("identifier low wrong");
	AST_ID_HIGH: assert property (rd && paddr == 16'h1358 |-> prdata == {16'h0000, `PMSAR_IDENT_HIGH_VAL})
		else $error("identifier high wrong");
	AST_ADV: assert property (rd && paddr == 16'h1360 && st == 4 |-> prdata == {21'h0, adv_ability[4], 1'b0, adv_ability[3:0], 5'h01})
		else $error("advertisement word wrong");
	AST_PARTNER: assert property (rd && paddr == 16'h1368 && st == 4 |-> prdata == {21'h0, lp_ability_in[4], 1'b0, lp_ability_in[3:0], 5'h00})
		else $error("partner ability word wrong");
endmodule // pmsar_chk
bind pmsar_phy_regs pmsar_chk u_chk (.pclk, .presetn, .pwrite, .paddr, .prdata, .pready,
	.an_complete_in, .far_fault_in, .lp_ability_in, .adv_ability, .an_enable);

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic an_complete_in = 0, far_fault_in = 0, link_up_in = 0, ae = 1;
	logic an_enable_we = 0, an_enable_wdata = 0, adv_ability_we = 0;
	logic [4:0] lp_ability_in = 0, adv_ability_wdata = 0, ea = 5'h1f;
	logic [15:0] rs = 16'h54e4;
	logic [32:0] q[$];
	wire [31:0] prdata;
	wire pready, pslverr, irq, an_enable;
	wire [4:0] adv_ability;
	int n_mismatch = 0, tests_run = 0, cyc = 0, i;
	pmsar_phy_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .an_complete_in, .far_fault_in,
		.link_up_in, .lp_ability_in, .an_enable_we, .an_enable_wdata, .adv_ability_we,
		.adv_ability_wdata, .adv_ability, .an_enable, .irq);
	initial forever #2.5 pclk = ~pclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [31:0] fld(input [4:0] x, input [4:0] lo);
		fld = {21'h0, x[4], 1'b0, x[3:0], lo};
	endfunction
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [31:0] eb;
		eb = {17'h0, 4'hf, 5'h0, an_complete_in, far_fault_in, ae, link_up_in, 2'b0};
	endfunction
	task chk(input [32:0] g, input [32:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task bus(input w, input [15:0] a, input [31:0] d, input [32:0] e);
		int k;
		k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q.push_back(e);
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(input [15:0] a, input [31:0] e);
		bus(0, a, 0, {1'b0, e});
	endtask
	task wr(input [15:0] a, input [31:0] d);
		bus(1, a, d, 0);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		if (pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
		if (++cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		rd(16'h1348, eb());
		rd(16'h1350, 32'h0000_5a5a);
		rd(16'h1358, 32'h0000_00c3);
		rd(16'h1360, fld(ea, 5'h01));
		rd(16'h1368, 32'h0000_0000);
		$display("reset test done");
		wr(16'h1350, 32'h0000_0000);
		wr(16'h1348, 32'h0000_0000);
		rd(16'h1350, 32'h0000_5a5a);
		rd(16'h1348, eb());
		wr(16'h1360, 32'hffff_ffff);
		rd(16'h1360, fld(ea, 5'h01));
		wr(16'h1360, 32'h0000_0000);
		ea = 5'h00;
		rd(16'h1360, fld(ea, 5'h01));
		bus(0, 16'h1380, 0, {1'b1, 32'h0000_0000});
		$display("write test done");
		for (i = 0; i < 24; i++)
		begin
			rs = lfsr(rs);
			{an_complete_in, far_fault_in, link_up_in, lp_ability_in} <= rs[7:0];
			an_enable_we <= rs[14];
			an_enable_wdata <= rs[8];
			adv_ability_we <= 1;
			adv_ability_wdata <= rs[13:9];
			if (rs[14]) ae = rs[8];
			ea = rs[13:9];
			@(posedge pclk);
			an_enable_we <= 0;
			adv_ability_we <= 0;
			repeat (3) @(posedge pclk);
			rd(16'h1348, eb());
			rd(16'h1368, fld(lp_ability_in, 5'h00));
			rd(16'h1360, fld(ea, 5'h01));
		end
		$display("mirror test done");
		an_complete_in <= 0;
		repeat (4) @(posedge pclk);
		wr(16'h1370, 32'h0000_000f);
		wr(16'h1378, 32'h0000_0000);
		an_complete_in <= 1;
		repeat (5) @(posedge pclk);
		chk(irq, 0);
		wr(16'h1378, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		rd(16'h1370, 32'h0000_0001);
		wr(16'h1370, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		$display("interrupt test done");
		repeat (4) @(posedge pclk);
		tally_and_finish;
	end
endmodule // testbench
